/* rwp_cfg.svh */
/*
  Constants for the ROM with two parallel ports: bus select codes, reset values,
  host register offsets and timing counts.
  Assumes a 200 MHz core clock; included by its bare name.
*/
// Function
// - 2048x8 memory; host selects by top five bits
// - word address is high pins plus latched byte
// - latch strobe captures low byte and enables
// - io/memory indicator routes cycle to ports or memory
// - memory byte driven during enabled read, else released
// - accesses ignored without asserted chip enables
// - host holds chip enable for whole cycle
// - low two bits select data or direction
// - per-bit direction register, one means output
// - reset makes every port pin input
// - direction writable in any port write; here only port writes with select bit 1 set load it
// - ports reached only through io strobes
// - host repeats port number on upper lines
// - ready driven, active while direction loads; here driven only while selected, and low during a direction load
// - ready changes on the clock
// - host waits while ready is low
`ifndef RWP_CFG_SVH
`define RWP_CFG_SVH

// ------------------------------------------------------------------
// port select codes on the two lowest address bits
// ------------------------------------------------------------------
`define RWP_SEL_DATA_A    2'h0
`define RWP_SEL_DATA_B    2'h1
`define RWP_SEL_DIR_A     2'h2
`define RWP_SEL_DIR_B     2'h3
`define RWP_SEL_DIR_BIT   1
`define RWP_SEL_PORT_BIT  0

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define RWP_DIR_RST       8'h00
`define RWP_OUT_RST       8'h00

// ------------------------------------------------------------------
// host register map (byte offsets) and fields
// ------------------------------------------------------------------
`define RWP_REG_ADDR      5'h00
`define RWP_REG_WDATA     5'h04
`define RWP_REG_CTRL      5'h08
`define RWP_REG_STATUS    5'h0C
`define RWP_REG_RDATA     5'h10
`define RWP_CTRL_KIND_LSB 0
`define RWP_STAT_BUSY_BIT 0

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define RWP_CLK_PERIOD_NS 5
`define RWP_T_ALE_NS      100
`define RWP_T_LC_NS       100
`define RWP_T_CC_NS       250
`define RWP_T_RV_NS       300
`define RWP_ALE_CYC       ((`RWP_T_ALE_NS + `RWP_CLK_PERIOD_NS - 1) / `RWP_CLK_PERIOD_NS)
`define RWP_LC_CYC        ((`RWP_T_LC_NS + `RWP_CLK_PERIOD_NS - 1) / `RWP_CLK_PERIOD_NS)
`define RWP_CC_CYC        ((`RWP_T_CC_NS + `RWP_CLK_PERIOD_NS - 1) / `RWP_CLK_PERIOD_NS)
`define RWP_RV_CYC        ((`RWP_T_RV_NS + `RWP_CLK_PERIOD_NS - 1) / `RWP_CLK_PERIOD_NS)
`define RWP_DDR_WAIT_CYC  4

`endif

/* rwp_pkg.sv */
/*
  Types shared by both ends of the ROM-with-ports bus.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rwp_pkg;
  // kind of bus cycle the host runs
  typedef enum logic [1:0] {KIND_MEM_RD, KIND_IO_RD, KIND_IO_WR} rwp_kind_t;
  // host bus sequencer states
  typedef enum logic [2:0] {HS_IDLE, HS_ALE, HS_SETUP, HS_STROBE, HS_RECOV} rwp_hst_t;
endpackage
`default_nettype wire

/* rwp_bus_if.sv */
/*
  Multiplexed processor bus between host and device ends.
  Assumes the bench supplies no drivers: the shared lines are resolved here,
  with the data bus and ready pulled high when nobody drives.
*/
`default_nettype none
interface rwp_bus_if;
  logic       ale;
  logic       io_m;
  logic       rd_n;
  logic       ior_n;
  logic       iow_n;
  logic       ce_n;
  logic       ce;
  logic [2:0] upper_memory_address;
  logic [7:0] host_ad_out;
  logic       host_ad_oe;
  logic [7:0] dev_ad_out;
  logic       dev_ad_oe;
  logic       rdy_out;
  logic       rdy_oe;
  logic [7:0] mux_addr_data_bus;
  logic       ready;

  // wire resolution of the shared lines
  assign mux_addr_data_bus = dev_ad_oe ? dev_ad_out : (host_ad_oe ? host_ad_out : 8'hFF);
  assign ready             = rdy_oe ? rdy_out : 1'b1;

  modport dev (input ale, io_m, rd_n, ior_n, iow_n, ce_n, ce, upper_memory_address, mux_addr_data_bus,
               output dev_ad_out, dev_ad_oe, rdy_out, rdy_oe);
  modport host (input mux_addr_data_bus, ready,
                output ale, io_m, rd_n, ior_n, iow_n, ce_n, ce, upper_memory_address, host_ad_out, host_ad_oe);
endinterface
`default_nettype wire

/* rwp_rom.sv */
/*
  2048 x 8 constant program memory with a registered read port.
  Assumes a stable word address; contents are a fixed pattern.
*/
`default_nettype none
module rwp_rom
  import rwp_pkg::*;
#(
  parameter int         AW   = 11,
  parameter logic [7:0] SEED = 8'h5A
) (
  input  wire logic          core_clk_in,
  input  wire logic          clk_en_in,
  input  wire logic [AW-1:0] addr_in,
  output logic      [7:0]    data_out
);
  logic [7:0] mem [0:(1<<AW)-1];

  // ---------------------------------------------------------------
  // constant contents, one entry per word
  // ---------------------------------------------------------------
  for (genvar i = 0; i < (1 << AW); i++) begin : g_word
    localparam logic [AW-1:0] IA = AW'(i);
    assign mem[i] = SEED ^ IA[7:0] ^ {5'h00, IA[AW-1:AW-3]};
  end

  // registered read
  always_ff @(posedge core_clk_in) begin
    if (clk_en_in) begin
      data_out <= mem[addr_in];
    end
  end
endmodule
`default_nettype wire

/* rwp_dev.sv */
/*
  Device end: program memory plus two 8-bit parallel ports on a
  multiplexed address/data bus with latch strobe and separate strobes.
  Assumes bus inputs synchronous to core_clk_in and a host that keeps
  chip enables steady for the whole cycle and waits on ready.
*/
`include "rwp_cfg.svh"
`default_nettype none
module rwp_dev
  import rwp_pkg::*;
#(
  parameter int         AW       = 11,
  parameter logic [7:0] ROM_SEED = 8'h5A
) (
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic       clk_en_in,
  rwp_bus_if.dev          bus,
  input  wire logic [7:0] first_port_pins_in,
  output logic      [7:0] first_port_pins_out,
  output logic      [7:0] first_port_pins_oe_out,
  input  wire logic [7:0] second_port_pins_in,
  output logic      [7:0] second_port_pins_out,
  output logic      [7:0] second_port_pins_oe_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  low_addr_r;       // low address byte from the latch strobe
  logic        io_cycle_r;       // cycle kind seen at the latch strobe
  logic        en_r;             // chip enables seen at the latch strobe
  logic        iow_prev_r;       // write strobe one cycle ago
  logic [7:0]  dir_r [0:1];      // per-port direction registers
  logic [7:0]  out_r [0:1];      // per-port output latches
  logic [7:0]  ad_out_r;
  logic [7:0]  ad_out_nxt;
  logic        ad_oe_r;
  logic        rdy_r;
  logic        rdy_oe_r;
  logic [3:0]  wait_cnt_r;
  logic [7:0]  rom_data;
  logic [7:0]  pin_in [0:1];
  logic [7:0]  port_rd [0:1];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire         chip_sel_now = ~bus.ce_n & bus.ce;
  wire         hit          = en_r & chip_sel_now;
  wire         mem_rd       = hit & ~io_cycle_r & ~bus.rd_n;
  wire         io_rd        = hit & io_cycle_r & ~bus.ior_n;
  wire         iow_lead     = hit & io_cycle_r & ~bus.iow_n & iow_prev_r;
  wire         iow_trail    = hit & io_cycle_r & bus.iow_n & ~iow_prev_r;
  wire  [1:0]  sel          = low_addr_r[1:0];
  wire         sel_dir      = sel[`RWP_SEL_DIR_BIT];
  wire         sel_port     = sel[`RWP_SEL_PORT_BIT];
  wire         ddr_load     = iow_lead & sel_dir;
  wire  [10:0] word_addr    = {bus.upper_memory_address, low_addr_r};
  wire  [7:0]  wr_data      = bus.mux_addr_data_bus;

  assign pin_in[0] = first_port_pins_in;
  assign pin_in[1] = second_port_pins_in;

  // ---------------------------------------------------------------
  // program memory
  // ---------------------------------------------------------------
  rwp_rom #(
    .AW   (AW),
    .SEED (ROM_SEED)
  ) u_rom (
    .core_clk_in (core_clk_in),
    .clk_en_in   (clk_en_in),
    .addr_in     (word_addr[AW-1:0]),
    .data_out    (rom_data)
  );

  // ---------------------------------------------------------------
  // address latch: low byte, kind and enables taken while strobe high
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      low_addr_r <= 8'h00;
      io_cycle_r <= 1'b0;
      en_r       <= 1'b0;
      iow_prev_r <= 1'b1;
    end else if (clk_en_in) begin
      iow_prev_r <= bus.iow_n;
      if (bus.ale) begin
        low_addr_r <= bus.mux_addr_data_bus;
        io_cycle_r <= bus.io_m;
        en_r       <= chip_sel_now;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-port direction and output latches
  // ---------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam logic PIDX = 1'(p);
    // direction taken at the end of a matching write strobe with select bit 1 set, else the output latch
    always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
        dir_r[p] <= `RWP_DIR_RST;
        out_r[p] <= `RWP_OUT_RST;
      end else if (clk_en_in && iow_trail && sel_port == PIDX) begin
        if (sel_dir) begin
          dir_r[p] <= wr_data;
        end else begin
          out_r[p] <= wr_data;
        end
      end
    end
    // outputs read back from the latch, inputs from the pins
    assign port_rd[p] = (dir_r[p] & out_r[p]) | (~dir_r[p] & pin_in[p]);
  end

  // ---------------------------------------------------------------
  // data bus driver select
  // ---------------------------------------------------------------
  always_comb begin
    ad_out_nxt = 8'h00;
    if (mem_rd) begin
      ad_out_nxt = rom_data;
    end else if (io_rd && !sel_dir) begin
      ad_out_nxt = port_rd[sel_port];
    end
  end

  // bus drive: memory byte or port value, released otherwise
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ad_out_r <= 8'h00;
      ad_oe_r  <= 1'b0;
    end else if (clk_en_in) begin
      ad_out_r <= ad_out_nxt;
      ad_oe_r  <= mem_rd | (io_rd & ~sel_dir);
    end
  end

  // ---------------------------------------------------------------
  // ready: driven while selected, low for a few cycles on a
  // direction load, all changes on the clock
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdy_r      <= 1'b1;
      rdy_oe_r   <= 1'b0;
      wait_cnt_r <= 4'h0;
    end else if (clk_en_in) begin
      rdy_oe_r <= hit;
      if (ddr_load) begin
        rdy_r      <= 1'b0;
        wait_cnt_r <= 4'(`RWP_DDR_WAIT_CYC - 1);
      end else if (!rdy_r) begin
        if (wait_cnt_r == 4'h0) begin
          rdy_r <= 1'b1;
        end else begin
          wait_cnt_r <= wait_cnt_r - 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.dev_ad_out          = ad_out_r;
  assign bus.dev_ad_oe           = ad_oe_r;
  assign bus.rdy_out             = rdy_r;
  assign bus.rdy_oe              = rdy_oe_r;
  assign first_port_pins_out     = out_r[0];
  assign first_port_pins_oe_out  = dir_r[0];
  assign second_port_pins_out    = out_r[1];
  assign second_port_pins_oe_out = dir_r[1];
endmodule
`default_nettype wire

/* rwp_host.sv */
/*
  Host end: runs memory read, port read and port write cycles on the
  multiplexed bus, ordered through registers on an Avalon-MM slave.
  Assumes a master that honours waitrequest and polls the busy bit.
*/
`include "rwp_cfg.svh"
`default_nettype none
module rwp_host
  import rwp_pkg::*;
#(
  parameter logic [4:0] CHIP_BASE = 5'h00
) (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  rwp_bus_if.host          bus,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out
);
  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  rwp_hst_t    st_r;
  rwp_kind_t   kind_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r, rdata_r;
  logic [7:0]  cnt_r;
  logic        busy_r, wait_r;
  logic [31:0] rdd_r;
  logic        ale_r, io_r, rd_n_r, ior_n_r, iow_n_r, ce_n_r, ce_r, ad_oe_r;
  logic [2:0]  hi_r;
  logic [7:0]  ad_r;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire         req     = (avs_read_in | avs_write_in) & wait_r;
  // a write lands only at the edge where waitrequest is seen low
  wire         wr_req  = avs_write_in & ~wait_r;
  wire         go      = wr_req & (avs_address_in == `RWP_REG_CTRL) & ~busy_r
                         & (avs_writedata_in[`RWP_CTRL_KIND_LSB +: 2] != 2'h3);
  // io cycles repeat the port number on the upper lines
  wire  [15:0] bus_addr = (kind_r == KIND_MEM_RD) ? addr_r : {addr_r[7:0], addr_r[7:0]};
  wire         chip_hit = bus_addr[15:11] == CHIP_BASE;
  wire  [31:0] rd_mux   = (avs_address_in == `RWP_REG_ADDR)   ? {16'h0000, addr_r} :
                          (avs_address_in == `RWP_REG_WDATA)  ? {24'h000000, wdata_r} :
                          (avs_address_in == `RWP_REG_STATUS) ? {31'h0, busy_r} :
                          (avs_address_in == `RWP_REG_RDATA)  ? {24'h000000, rdata_r} : 32'h0;

  // slave: one-cycle answer to every access, unmapped reads give zero
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wait_r  <= 1'b1;
      rdd_r   <= 32'h0;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
    end else if (clk_en_in) begin
      wait_r <= ~req;
      if (avs_read_in && wait_r) begin
        rdd_r <= rd_mux;
      end
      if (wr_req && avs_address_in == `RWP_REG_ADDR && !busy_r) begin
        addr_r <= avs_writedata_in[15:0];
      end
      if (wr_req && avs_address_in == `RWP_REG_WDATA && !busy_r) begin
        wdata_r <= avs_writedata_in[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // bus cycle sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_r <= HS_IDLE;
      kind_r <= KIND_MEM_RD;
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      rdata_r <= 8'h00;
      ale_r <= 1'b0;
      io_r <= 1'b0;
      rd_n_r <= 1'b1;
      ior_n_r <= 1'b1;
      iow_n_r <= 1'b1;
      ce_n_r <= 1'b1;
      ce_r <= 1'b0;
      ad_oe_r <= 1'b0;
      hi_r <= 3'h0;
      ad_r <= 8'h00;
    end else if (clk_en_in) begin
      case (st_r)
        HS_IDLE: begin
          ce_n_r <= 1'b1;
          ce_r   <= 1'b0;
          if (go) begin
            kind_r <= rwp_kind_t'(avs_writedata_in[`RWP_CTRL_KIND_LSB +: 2]);
            busy_r <= 1'b1;
            st_r   <= HS_ALE;
            cnt_r  <= 8'(`RWP_ALE_CYC - 1);
          end
        end
        HS_ALE: begin
          ale_r   <= 1'b1;
          io_r    <= kind_r != KIND_MEM_RD;
          ce_n_r  <= ~chip_hit;
          ce_r    <= chip_hit;
          hi_r    <= bus_addr[10:8];
          ad_r    <= bus_addr[7:0];
          ad_oe_r <= 1'b1;
          if (cnt_r == 8'h00) begin
            st_r  <= HS_SETUP;
            cnt_r <= 8'(`RWP_LC_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        HS_SETUP: begin
          ale_r   <= 1'b0;
          ad_r    <= wdata_r;
          ad_oe_r <= kind_r == KIND_IO_WR;
          if (cnt_r == 8'h00) begin
            st_r  <= HS_STROBE;
            cnt_r <= 8'(`RWP_CC_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        HS_STROBE: begin
          rd_n_r  <= kind_r != KIND_MEM_RD;
          ior_n_r <= kind_r != KIND_IO_RD;
          iow_n_r <= kind_r != KIND_IO_WR;
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (bus.ready) begin
            rdata_r <= bus.mux_addr_data_bus;
            st_r    <= HS_RECOV;
            cnt_r   <= 8'(`RWP_RV_CYC - 1);
          end
        end
        HS_RECOV: begin
          rd_n_r  <= 1'b1;
          ior_n_r <= 1'b1;
          iow_n_r <= 1'b1;
          if (cnt_r == 8'h00) begin
            ad_oe_r <= 1'b0;
            busy_r  <= 1'b0;
            st_r    <= HS_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.ale                  = ale_r;
  assign bus.io_m                 = io_r;
  assign bus.rd_n                 = rd_n_r;
  assign bus.ior_n                = ior_n_r;
  assign bus.iow_n                = iow_n_r;
  assign bus.ce_n                 = ce_n_r;
  assign bus.ce                   = ce_r;
  assign bus.upper_memory_address = hi_r;
  assign bus.host_ad_out          = ad_r;
  assign bus.host_ad_oe           = ad_oe_r;
  assign avs_readdata_out         = rdd_r;
  assign avs_waitrequest_out      = wait_r;
endmodule
`default_nettype wire

/* rwp_chk.sv */
/*
  Concurrent checks on the bus between the host and device ends.
  Assumes instantiation beside the interface, every signal connected by name.
*/
`default_nettype none
module rwp_chk (
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic       ale,
  input wire logic       io_m,
  input wire logic       rd_n,
  input wire logic       ior_n,
  input wire logic       iow_n,
  input wire logic       ce_n,
  input wire logic       ce,
  input wire logic [2:0] upper_memory_address,
  input wire logic       dev_ad_oe,
  input wire logic       rdy_oe,
  input wire logic [7:0] mux_addr_data_bus,
  input wire logic       ready
);
  logic [1:0] sel_r;
  wire        strobe_on = !rd_n || !ior_n || !iow_n;
  wire        chip_on   = !ce_n && ce;

  // port select as latched at the address strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sel_r <= 2'h0;
    end else if (ale) begin
      sel_r <= mux_addr_data_bus[1:0];
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  sequence ddr_load_s;
    $fell(iow_n) && io_m && chip_on && sel_r[1];
  endsequence
  sequence data_write_s;
    $fell(iow_n) && io_m && chip_on && !sel_r[1];
  endsequence

  a_ale_width: assert property ($rose(ale) |-> ale[*8] ##12 ale ##1 !ale)
    else $error("latch strobe width wrong");
  a_ddr_ready: assert property (ddr_load_s |-> ##[0:2] !ready)
    else $error("ready not low on direction load");
  a_ready_back: assert property ($fell(ready) |-> !ready[*3] ##[1:2] ready)
    else $error("ready low for wrong span");
  a_data_no_wait: assert property (data_write_s |-> ready[*4])
    else $error("ready low on data write");
  a_wait_held: assert property (!ready && !iow_n |=> !iow_n)
    else $error("write strobe ended while not ready");
  a_ce_steady: assert property (strobe_on && $past(strobe_on) |-> $stable(ce_n) && $stable(ce))
    else $error("chip enable moved during strobe");
  a_upper_dup: assert property (ale && io_m |-> upper_memory_address == mux_addr_data_bus[2:0])
    else $error("port number not on upper lines");
  a_mem_drive: assert property (dev_ad_oe && !io_m |-> $past(!rd_n) && $past(chip_on))
    else $error("memory data driven without read");
  a_io_drive: assert property (dev_ad_oe && io_m |-> $past(!ior_n) && !sel_r[1])
    else $error("port data driven wrongly");
  a_idle_float: assert property (!chip_on && !$past(chip_on) |-> !dev_ad_oe && !rdy_oe)
    else $error("device drives while deselected");
endmodule
`default_nettype wire

/* tb_rom_with_two_io_ports.sv */
/*
  Testbench: host and device ends joined by the bus interface, the host
  ordered over Avalon-MM. Assumes the default host chip base of zero.
*/
`include "rwp_cfg.svh"
`default_nettype none
module tb_rom_with_two_io_ports
  import rwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ROM_SEED = 8'h5A;
  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic [7:0]  a_pins   = 8'h00;
  logic [7:0]  b_pins   = 8'h00;
  logic [4:0]  avs_addr = 5'h00;
  logic        avs_rd   = 1'b0;
  logic        avs_wr   = 1'b0;
  logic [31:0] avs_wd   = 32'h0;
  logic [31:0] avs_rdat;
  logic        avs_wait;
  logic [7:0]  a_out, a_oe, b_out, b_oe;
  int          n_fail       = 0;
  int          total_checks = 0;

  rwp_bus_if bus();
  always #2.5 clk = ~clk;

  rwp_dev #(.ROM_SEED(ROM_SEED)) rwp_dev_i (.core_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1), .bus(bus.dev),
    .first_port_pins_in(a_pins), .first_port_pins_out(a_out), .first_port_pins_oe_out(a_oe),
    .second_port_pins_in(b_pins), .second_port_pins_out(b_out), .second_port_pins_oe_out(b_oe));
  rwp_host rwp_host_i (.core_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1), .bus(bus.host),
    .avs_address_in(avs_addr), .avs_read_in(avs_rd), .avs_write_in(avs_wr), .avs_writedata_in(avs_wd),
    .avs_readdata_out(avs_rdat), .avs_waitrequest_out(avs_wait));
  rwp_chk rwp_chk_i (.core_clk_in(clk), .reset_in(rst), .ale(bus.ale), .io_m(bus.io_m), .rd_n(bus.rd_n),
    .ior_n(bus.ior_n), .iow_n(bus.iow_n), .ce_n(bus.ce_n), .ce(bus.ce),
    .upper_memory_address(bus.upper_memory_address), .dev_ad_oe(bus.dev_ad_oe), .rdy_oe(bus.rdy_oe),
    .mux_addr_data_bus(bus.mux_addr_data_bus), .ready(bus.ready));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one Avalon transfer, held until waitrequest is seen low
  task automatic avs(input logic [4:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_addr <= a;
    avs_wr <= wr;
    avs_rd <= !wr;
    avs_wd <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 50);
    rd = avs_rdat;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
    if (n >= 50) n_fail++;
    @(posedge clk);
  endtask

  // one bus cycle ordered through the host registers
  task automatic cyc(input logic [1:0] kind, input logic [15:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    logic [31:0] r;
    int          n;
    avs(`RWP_REG_ADDR, 1'b1, {16'h0, addr}, r);
    avs(`RWP_REG_WDATA, 1'b1, {24'h0, wd}, r);
    avs(`RWP_REG_CTRL, 1'b1, {30'h0, kind}, r);
    n = 0;
    r = 32'h1;
    while (r[`RWP_STAT_BUSY_BIT] !== 1'b0 && n < 200) begin
      avs(`RWP_REG_STATUS, 1'b0, 32'h0, r);
      n++;
    end
    if (n >= 200) n_fail++;
    avs(`RWP_REG_RDATA, 1'b0, 32'h0, r);
    rd = r[7:0];
  endtask

  function automatic logic [7:0] rom_exp(input logic [10:0] a);
    return ROM_SEED ^ a[7:0] ^ {5'h00, a[10:8]};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_state();
    chk(a_oe, `RWP_DIR_RST);
    chk(b_oe, `RWP_DIR_RST);
    chk(a_out, `RWP_OUT_RST);
    chk(b_out, `RWP_OUT_RST);
  endtask

  task automatic t_rom();
    logic [7:0]  d;
    logic [10:0] a [3];
    a = '{11'h000, 11'h7A5, 11'h312};
    foreach (a[i]) begin
      cyc(KIND_MEM_RD, {5'h00, a[i]}, 8'h00, d);
      chk(d, rom_exp(a[i]));
    end
  endtask

  task automatic t_miss();
    logic [7:0] d;
    cyc(KIND_MEM_RD, 16'h0800, 8'h00, d);
    chk(d, 8'hFF);
    // port 0x0A repeats to upper byte 0x0A: top five bits miss the chip
    cyc(KIND_IO_WR, 16'h0A0A, 8'hFF, d);
    chk(a_oe, `RWP_DIR_RST);
  endtask

  task automatic t_dir();
    logic [7:0] d;
    cyc(KIND_IO_WR, 16'h0202, 8'h0F, d);
    cyc(KIND_IO_WR, 16'h0202, 8'hF0, d);
    cyc(KIND_IO_WR, 16'h0303, 8'h0F, d);
    chk(a_oe, 8'hF0);
    chk(b_oe, 8'h0F);
    cyc(KIND_IO_RD, 16'h0202, 8'h00, d);
    chk(d, 8'hFF);
  endtask

  task automatic t_port();
    logic [7:0] d;
    a_pins <= 8'h3C;
    b_pins <= 8'hC3;
    cyc(KIND_IO_WR, 16'h0000, 8'hA5, d);
    cyc(KIND_IO_WR, 16'h0101, 8'h5A, d);
    chk(a_out, 8'hA5);
    chk(b_out, 8'h5A);
    cyc(KIND_IO_RD, 16'h0000, 8'h00, d);
    chk(d, (8'hA5 & 8'hF0) | (8'h3C & 8'h0F));
    cyc(KIND_IO_RD, 16'h0101, 8'h00, d);
    chk(d, (8'h5A & 8'h0F) | (8'hC3 & 8'hF0));
    cyc(KIND_MEM_RD, 16'h0001, 8'h00, d);
    chk(d, rom_exp(11'h001));
  endtask

  task automatic t_midreset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_state();
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_state();
    t_rom();
    t_miss();
    t_dir();
    t_port();
    t_midreset();
    print_verdict();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
